// *** crpg_mixer.sv ***
// Four-input mixer producing a pulse duty value from gained audio sources
`timescale 1ns/1ps
module crpg_mixer
	import crpg_pkg::*;
(
	input  wire logic               i_clk_sys,
	input  wire logic               i_arst_n,
	input  wire logic [7:0]         i_sel   [4],
	input  wire logic [7:0]         i_gain  [4],
	input  wire logic signed [15:0] i_audio [4],
	output logic      [7:0]         o_duty
);

	logic signed [25:0] acc;
	logic signed [15:0] sat;

	always_comb
	begin
		acc = '0;
		for (int k = 0; k < 4; k++)
		begin
			// Idle inputs add nothing even if the routing still presents data
			if (i_sel[k] != SRC_NONE)
				acc = acc + 26'(($signed(i_audio[k]) * $signed({1'b0, i_gain[k]})) >>> 7);
		end
		if (acc > 26'sd32767)
			sat = 16'sh7FFF;
		else if (acc < -26'sd32768)
			sat = -16'sh8000;
		else
			sat = acc[15:0];
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
			o_duty <= LVL_RST;
		else
			o_duty <= {~sat[15], sat[14:8]};
	end

endmodule : crpg_mixer

// *** crpg_pkg.sv ***
// Register map, field layout and shared helpers for the rate and pulse generator block
package crpg_pkg;

	localparam int          RATE_N        = 12;
	localparam int          R_IN          = 0;
	localparam int          R_OUT         = 1;
	localparam int          R_PORT1       = 2;
	localparam int          R_PORT2       = 3;
	localparam int          R_PORT3       = 4;
	localparam int          R_FX          = 5;
	localparam int          R_CORE2       = 6;
	localparam int          R_CORE3       = 7;
	localparam int          R_TONE        = 8;
	localparam int          R_NOISE       = 9;
	localparam int          R_VIBE        = 10;
	localparam int          R_PULSE       = 11;

	// Register indices; the bus byte address is four times the index
	localparam logic [15:0] RATE_IDX [RATE_N] = '{
		16'h0E10, 16'h0E11, 16'h0E12, 16'h0E13, 16'h0E14, 16'h0E00,
		16'h1200, 16'h1300, 16'h0E15, 16'h0E16, 16'h0E17, 16'h0E18};
	localparam logic [15:0] MIX_FIRST_IDX = 16'h0640;
	localparam logic [15:0] MIX_LAST_IDX  = 16'h064F;
	localparam logic [15:0] PULSE_CTRL_IDX = 16'h0030;
	localparam logic [15:0] PULSE_LVL1_IDX = 16'h0031;
	localparam logic [15:0] PULSE_LVL2_IDX = 16'h0032;
	localparam logic [15:0] CLK_BUDGET_IDX = 16'h0E20;
	localparam logic [15:0] ERR_STAT_IDX   = 16'h0E21;

	// Rate-select field, bits 14:11
	localparam int          RATE_LSB      = 11;
	localparam int          RATE_MSB      = 14;
	localparam logic [3:0]  RATE_RST      = 4'h0;
	localparam logic [3:0]  RATE_SYS1     = 4'h0;
	localparam logic [3:0]  RATE_SYS2     = 4'h1;
	localparam logic [3:0]  RATE_SYS3     = 4'h2;
	localparam logic [3:0]  RATE_ALT1     = 4'h8;
	localparam logic [3:0]  RATE_ALT2     = 4'h9;

	// Pulse control register fields
	localparam int          CTRL_EN1_BIT  = 0;
	localparam int          CTRL_EN2_BIT  = 1;
	localparam int          CTRL_OVD1_BIT = 4;
	localparam int          CTRL_OVD2_BIT = 5;
	localparam int          CTRL_CLK_LSB  = 8;
	localparam logic [1:0]  CLK_SEL_RST   = 2'h0;
	localparam logic [7:0]  LVL_RST       = 8'h80;

	// Mixer: source select in 7:0, mixer-active status (any input of the group routed) in bit 15
	localparam int          MIX_STAT_BIT  = 15;
	localparam logic [7:0]  SRC_NONE      = 8'h00;
	localparam logic [7:0]  SRC_MAX       = 8'h5F;
	localparam logic [7:0]  VOL_RST       = 8'h80;

	// Clock sufficiency check
	localparam logic [15:0] PATH_CYCLES   = 16'h0010;
	localparam logic [15:0] BUDGET_RST    = 16'h0080;
	localparam int          ERR_UNDER_BIT = 0;

	localparam logic [7:0]  PULSE_PERIOD_LAST = 8'hFF;

	function automatic logic rate_ok(input logic [3:0] code);
		return (code == RATE_SYS1) || (code == RATE_SYS2) || (code == RATE_SYS3) ||
			(code == RATE_ALT1) || (code == RATE_ALT2);
	endfunction : rate_ok

	// The pulse generators own no source code, so no legal code can route them
	function automatic logic src_ok(input logic [7:0] code);
		return code <= SRC_MAX;
	endfunction : src_ok

endpackage : crpg_pkg

// *** crpg_properties.sv ***
// Port-level assertions for the rate and pulse generator block
`timescale 1ns/1ps
module crpg_properties
	import crpg_pkg::*;
(
	input  wire logic        i_clk_sys,
	input  wire logic        i_arst_n,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [15:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	input  wire logic [31:0] o_prdata,
	input  wire logic        o_pready,
	input  wire logic        o_pslverr,
	input  wire logic [7:0]  o_mix1_sel [4],
	input  wire logic [3:0]  o_rate_sel [RATE_N],
	input  wire logic        o_rate_alt [RATE_N],
	input  wire logic        o_underclock_err
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_arst_n);
	logic       acc;
	logic       wr;
	logic       fx_hit;
	logic       mix_hit;
	logic       clr;
	logic       fx_ok;
	logic [3:0] fxc;
	assign acc = i_psel && i_penable;
	assign wr = acc && i_pwrite;
	assign fx_hit = i_paddr[15:2] == RATE_IDX[R_FX][13:0];
	assign mix_hit = i_paddr[15:2] == MIX_FIRST_IDX[13:0];
	assign clr = wr && i_pwdata[ERR_UNDER_BIT] && (i_paddr[15:2] == ERR_STAT_IDX[13:0]);
	assign fxc = i_pwdata[RATE_MSB:RATE_LSB];
	assign fx_ok = fxc inside {RATE_SYS1, RATE_SYS2, RATE_SYS3, RATE_ALT1, RATE_ALT2};
	a_pready_in_access: assert property (o_pready == acc) else $error("pready outside access");
	a_effects_rate_write: assert property (wr && fx_hit && fx_ok |=> o_rate_sel[R_FX] == $past(fxc))
		else $error("effects_rate not taken");
	a_fx_reserved_kept: assert property (wr && fx_hit && !fx_ok |=> $stable(o_rate_sel[R_FX]))
		else $error("reserved effects_rate taken");
	for (genvar k = 0; k < RATE_N; k++)
	begin : g_rate
		a_rate_alt_domain: assert property (o_rate_alt[k] == o_rate_sel[k][3])
			else $error("domain flag wrong");
		a_rate_code_legal: assert property (o_rate_sel[k] inside {4'h0, 4'h1, 4'h2, 4'h8, 4'h9})
			else $error("illegal rate code held");
	end
	for (genvar k = 0; k < 4; k++)
	begin : g_src
		a_src_in_range: assert property (o_mix1_sel[k] <= SRC_MAX)
			else $error("source code beyond limit");
	end
	a_err_sticky: assert property (o_underclock_err && !clr |=> o_underclock_err)
		else $error("underclock error dropped");
	a_err_has_cause: assert property ($rose(o_underclock_err) |-> $past(wr))
		else $error("underclock error without write");
	a_sel_by_write: assert property ($changed(o_mix1_sel[0]) |-> $past(wr && mix_hit))
		else $error("mixer select changed alone");
	a_slverr_read_zero: assert property (o_pslverr && !i_pwrite |-> o_prdata == 32'h0)
		else $error("unmapped read not zero");
endmodule : crpg_properties

// *** crpg_pulse.sv ***
// One pulse width generator with divided clock and duty source choice
`timescale 1ns/1ps
module crpg_pulse
	import crpg_pkg::*;
(
	input  wire logic       i_clk_sys,
	input  wire logic       i_arst_n,
	input  wire logic       i_enable,
	input  wire logic       i_override,
	input  wire logic [7:0] i_level,
	input  wire logic [7:0] i_mix_duty,
	input  wire logic [1:0] i_clk_sel,
	output logic            o_pwm
);

	logic [7:0] div_q;
	logic [7:0] cnt_q;
	logic [7:0] duty_q;
	logic       tick;

	assign tick = (div_q == 8'((8'h01 << i_clk_sel) - 8'h01));

	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
			div_q <= 8'h00;
		else if (!i_enable || tick)
			div_q <= 8'h00;
		else
			div_q <= div_q + 8'h01;
	end

	// Duty is taken only at period start so a cycle never gets a torn width
	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			cnt_q  <= 8'h00;
			duty_q <= 8'h00;
		end
		else if (!i_enable)
		begin
			cnt_q  <= 8'h00;
			duty_q <= 8'h00;
		end
		else if (tick)
		begin
			cnt_q <= cnt_q + 8'h01;
			if (cnt_q == PULSE_PERIOD_LAST)
				duty_q <= i_override ? i_level : i_mix_duty;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
			o_pwm <= 1'b0;
		else
			o_pwm <= i_enable && (cnt_q < duty_q);
	end

endmodule : crpg_pulse

// *** crpg_top.sv ***
// Sample rate control, pulse generator mixers and APB register file
// Overview of operation
// - Pulse generator outputs are never offered as mixer or processing sources.
// - Pulse generator mixer registers occupy indices 640h through 64Fh.
// - Each pulse generator has its own enable bit switching it.
// - Without override, duty comes from that generator's four-input mixer.
// - With override set, duty is the fixed level register value.
// - Path enables lacking clock budget are refused and raise underclock error.
// - Each mixer shows a readable status bit of actual enablement.
// - Five rate slots: three system clock, two alternate domain.
// - Every path belongs to exactly one of the two clock domains.
// - Input rate field drives microphones; output field drives outputs and loopback.
// - Each of three serial ports has its own rate field.
// - Rate fields in bits 14:11; codes 0,1,2,8,9 legal, others reserved.
// - Each processor core has its own rate field, 4 to 192kHz.
// - Tone, noise, vibe and pulse generators each have own rate field.
`timescale 1ns/1ps
module crpg_top
	import crpg_pkg::*;
(
	input  wire logic               i_clk_sys,
	input  wire logic               i_arst_n,
	input  wire logic               i_psel,
	input  wire logic               i_penable,
	input  wire logic               i_pwrite,
	input  wire logic [15:0]        i_paddr,
	input  wire logic [31:0]        i_pwdata,
	output logic      [31:0]        o_prdata,
	output logic                    o_pready,
	output logic                    o_pslverr,
	input  wire logic signed [15:0] i_mix1_audio [4],
	input  wire logic signed [15:0] i_mix2_audio [4],
	output logic      [7:0]         o_mix1_sel   [4],
	output logic      [7:0]         o_mix2_sel   [4],
	output logic      [3:0]         o_rate_sel   [RATE_N],
	output logic                    o_rate_alt   [RATE_N],
	output logic                    o_pwm1,
	output logic                    o_pwm2,
	output logic                    o_underclock_err
);

	logic [3:0]  rate_q [RATE_N];
	logic [7:0]  src_q  [2][4];
	logic [7:0]  vol_q  [2][4];
	logic [1:0]  en_q;
	logic [1:0]  ovd_q;
	logic [1:0]  clk_sel_q;
	logic [7:0]  lvl_q  [2];
	logic [15:0] budget_q;
	logic        err_q;
	logic [31:0] rdata_q;
	logic        slverr_q;

	logic [15:0] idx;
	logic        setup;
	logic        wr;
	logic        mix_hit;
	logic        mix_grp;
	logic [1:0]  mix_inp;
	logic        mix_vol;
	logic [RATE_N-1:0] rate_hit;
	logic        any_hit;
	logic [3:0]  wr_rate;
	logic [7:0]  wr_src;
	logic [3:0]  active_n;
	logic [15:0] used_cyc;
	logic        path_on;
	logic        refuse;
	logic [1:0]  mix_active;
	logic [7:0]  mix_duty [2];
	logic [31:0] rd_mux;

	assign idx     = {2'b00, i_paddr[15:2]};
	assign setup   = i_psel && !i_penable;
	assign wr      = i_psel && i_penable && i_pwrite;
	assign wr_rate = i_pwdata[RATE_MSB:RATE_LSB];
	assign wr_src  = i_pwdata[7:0];

	assign mix_hit = (idx >= MIX_FIRST_IDX) && (idx <= MIX_LAST_IDX);
	assign mix_grp = i_paddr[5];
	assign mix_inp = i_paddr[4:3];
	assign mix_vol = i_paddr[2];

	always_comb
	begin
		for (int r = 0; r < RATE_N; r++)
			rate_hit[r] = (idx == RATE_IDX[r]);
		any_hit = mix_hit || (|rate_hit) || (idx == PULSE_CTRL_IDX) ||
			(idx == PULSE_LVL1_IDX) || (idx == PULSE_LVL2_IDX) ||
			(idx == CLK_BUDGET_IDX) || (idx == ERR_STAT_IDX);
	end

	// Running paths, each costing a fixed slice of system clock cycles
	always_comb
	begin
		active_n = 4'h0;
		for (int g = 0; g < 2; g++)
			for (int k = 0; k < 4; k++)
				active_n = active_n + {3'b000, src_q[g][k] != SRC_NONE};
		mix_active[0] = |{src_q[0][0], src_q[0][1], src_q[0][2], src_q[0][3]};
		mix_active[1] = |{src_q[1][0], src_q[1][1], src_q[1][2], src_q[1][3]};
	end

	assign used_cyc = 16'(active_n * PATH_CYCLES);
	// A write turns a path on only when it was idle and the new code is nonzero
	assign path_on  = wr && mix_hit && !mix_vol && (wr_src != SRC_NONE) &&
		src_ok(wr_src) && (src_q[mix_grp][mix_inp] == SRC_NONE);
	assign refuse   = path_on && ((used_cyc + PATH_CYCLES) > budget_q);

	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			for (int r = 0; r < RATE_N; r++)
				rate_q[r] <= RATE_RST;
		end
		else if (wr)
		begin
			for (int r = 0; r < RATE_N; r++)
				if (rate_hit[r] && rate_ok(wr_rate))
					rate_q[r] <= wr_rate;
		end
	end

	always_comb
	begin
		for (int r = 0; r < RATE_N; r++)
		begin
			o_rate_sel[r] = rate_q[r];
			o_rate_alt[r] = rate_q[r][3];
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			for (int g = 0; g < 2; g++)
				for (int k = 0; k < 4; k++)
				begin
					src_q[g][k] <= SRC_NONE;
					vol_q[g][k] <= VOL_RST;
				end
		end
		else if (wr && mix_hit)
		begin
			if (mix_vol)
				vol_q[mix_grp][mix_inp] <= i_pwdata[7:0];
			else if (src_ok(wr_src) && !refuse)
				src_q[mix_grp][mix_inp] <= wr_src;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			en_q      <= 2'b00;
			ovd_q     <= 2'b00;
			clk_sel_q <= CLK_SEL_RST;
			lvl_q[0]  <= LVL_RST;
			lvl_q[1]  <= LVL_RST;
			budget_q  <= BUDGET_RST;
		end
		else if (wr)
		begin
			if (idx == PULSE_CTRL_IDX)
			begin
				en_q      <= {i_pwdata[CTRL_EN2_BIT], i_pwdata[CTRL_EN1_BIT]};
				ovd_q     <= {i_pwdata[CTRL_OVD2_BIT], i_pwdata[CTRL_OVD1_BIT]};
				clk_sel_q <= i_pwdata[CTRL_CLK_LSB +: 2];
			end
			if (idx == PULSE_LVL1_IDX)
				lvl_q[0] <= i_pwdata[7:0];
			if (idx == PULSE_LVL2_IDX)
				lvl_q[1] <= i_pwdata[7:0];
			if (idx == CLK_BUDGET_IDX)
				budget_q <= i_pwdata[15:0];
		end
	end

	// sticky error, set wins over clear
	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
			err_q <= 1'b0;
		else if (refuse)
			err_q <= 1'b1;
		else if (wr && (idx == ERR_STAT_IDX) && i_pwdata[ERR_UNDER_BIT])
			err_q <= 1'b0;
	end

	assign o_underclock_err = err_q;

	always_comb
	begin
		rd_mux = 32'h0000_0000;
		for (int r = 0; r < RATE_N; r++)
			if (rate_hit[r])
				rd_mux[RATE_MSB:RATE_LSB] = rate_q[r];
		if (mix_hit)
		begin
			if (mix_vol)
				rd_mux[7:0] = vol_q[mix_grp][mix_inp];
			else
			begin
				rd_mux[7:0] = src_q[mix_grp][mix_inp];
				rd_mux[MIX_STAT_BIT] = mix_active[mix_grp];
			end
		end
		if (idx == PULSE_CTRL_IDX)
		begin
			rd_mux[CTRL_EN1_BIT]       = en_q[0];
			rd_mux[CTRL_EN2_BIT]       = en_q[1];
			rd_mux[CTRL_OVD1_BIT]      = ovd_q[0];
			rd_mux[CTRL_OVD2_BIT]      = ovd_q[1];
			rd_mux[CTRL_CLK_LSB +: 2]  = clk_sel_q;
		end
		if (idx == PULSE_LVL1_IDX)
			rd_mux[7:0] = lvl_q[0];
		if (idx == PULSE_LVL2_IDX)
			rd_mux[7:0] = lvl_q[1];
		if (idx == CLK_BUDGET_IDX)
			rd_mux[15:0] = budget_q;
		if (idx == ERR_STAT_IDX)
			rd_mux[ERR_UNDER_BIT] = err_q;
	end

	// Read data is captured in the setup cycle so the access phase needs no wait
	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			rdata_q  <= 32'h0000_0000;
			slverr_q <= 1'b0;
		end
		else if (setup)
		begin
			rdata_q  <= i_pwrite ? 32'h0000_0000 : rd_mux;
			slverr_q <= !any_hit;
		end
	end

	assign o_prdata  = rdata_q;
	assign o_pready  = i_psel && i_penable;
	assign o_pslverr = i_psel && i_penable && slverr_q;

	always_comb
	begin
		for (int k = 0; k < 4; k++)
		begin
			o_mix1_sel[k] = src_q[0][k];
			o_mix2_sel[k] = src_q[1][k];
		end
	end

	crpg_mixer u_mix1 (
		.i_clk_sys (i_clk_sys),
		.i_arst_n  (i_arst_n),
		.i_sel     (src_q[0]),
		.i_gain    (vol_q[0]),
		.i_audio   (i_mix1_audio),
		.o_duty    (mix_duty[0])
	);

	crpg_mixer u_mix2 (
		.i_clk_sys (i_clk_sys),
		.i_arst_n  (i_arst_n),
		.i_sel     (src_q[1]),
		.i_gain    (vol_q[1]),
		.i_audio   (i_mix2_audio),
		.o_duty    (mix_duty[1])
	);

	// Output freezes if the system clock stops, hence software must disable first
	crpg_pulse u_pulse1 (
		.i_clk_sys  (i_clk_sys),
		.i_arst_n   (i_arst_n),
		.i_enable   (en_q[0]),
		.i_override (ovd_q[0]),
		.i_level    (lvl_q[0]),
		.i_mix_duty (mix_duty[0]),
		.i_clk_sel  (clk_sel_q),
		.o_pwm      (o_pwm1)
	);

	crpg_pulse u_pulse2 (
		.i_clk_sys  (i_clk_sys),
		.i_arst_n   (i_arst_n),
		.i_enable   (en_q[1]),
		.i_override (ovd_q[1]),
		.i_level    (lvl_q[1]),
		.i_mix_duty (mix_duty[1]),
		.i_clk_sel  (clk_sel_q),
		.o_pwm      (o_pwm2)
	);

endmodule : crpg_top

// *** crpg_top_bench.sv ***
// Directed testbench for the rate and pulse generator block
`timescale 1ns/1ps
module crpg_top_bench;
	import crpg_pkg::*;
	logic               clk;
	logic               arst_n;
	logic               psel, penable, pwrite, pready, pslverr, pwm1, pwm2, uerr, serr;
	logic        [15:0] paddr;
	logic        [31:0] pwdata, prdata, rd;
	logic signed [15:0] au1 [4];
	logic signed [15:0] au2 [4];
	logic        [7:0]  sel1 [4];
	logic        [7:0]  sel2 [4];
	logic        [3:0]  rsel [RATE_N];
	logic               ralt [RATE_N];
	int                 n_mismatch = 0;
	int                 tests_run = 0;
	int                 cyc = 0;

	crpg_top DUT (.i_clk_sys(clk), .i_arst_n(arst_n), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_mix1_audio(au1), .i_mix2_audio(au2),
		.o_mix1_sel(sel1), .o_mix2_sel(sel2), .o_rate_sel(rsel), .o_rate_alt(ralt),
		.o_pwm1(pwm1), .o_pwm2(pwm2), .o_underclock_err(uerr));

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : stop_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Holds the request until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] wd);
		@(posedge clk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= {idx[13:0], 2'b00};
		pwdata  <= wd;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rd = prdata;
		serr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Any settled window of m cycles, m being one pulse period, holds exactly one period
	task automatic count_pwm(input int n, input int m, output int h1, output int h2);
		repeat (n) @(posedge clk);
		h1 = 0;
		h2 = 0;
		repeat (m)
		begin
			@(negedge clk);
			h1 += int'(pwm1 === 1'b1);
			h2 += int'(pwm2 === 1'b1);
		end
	endtask : count_pwm

	task automatic t_reset();
		for (int k = 0; k < RATE_N; k++)
			chk(32'(rsel[k]), 32'h0);
		apb(1'b0, CLK_BUDGET_IDX, 32'h0);
		chk(rd, 32'h0000_0080);
		apb(1'b0, PULSE_LVL1_IDX, 32'h0);
		chk(rd, 32'h0000_0080);
	endtask : t_reset

	task automatic t_rates();
		logic [3:0] codes [5] = '{RATE_SYS1, RATE_SYS2, RATE_SYS3, RATE_ALT1, RATE_ALT2};
		foreach (codes[k])
		begin
			apb(1'b1, RATE_IDX[R_FX], 32'(codes[k]) << RATE_LSB);
			@(negedge clk);
			chk(32'(rsel[R_FX]), 32'(codes[k]));
			chk(32'(ralt[R_FX]), 32'(codes[k][3]));
			apb(1'b0, RATE_IDX[R_FX], 32'h0);
			chk(rd, 32'(codes[k]) << RATE_LSB);
		end
		apb(1'b1, RATE_IDX[R_FX], 32'h5 << RATE_LSB);
		apb(1'b1, RATE_IDX[R_PULSE], 32'(RATE_SYS2) << RATE_LSB);
		apb(1'b1, RATE_IDX[R_OUT], 32'(RATE_SYS3) << RATE_LSB);
		apb(1'b1, RATE_IDX[R_PORT1], 32'(RATE_SYS2) << RATE_LSB);
		@(negedge clk);
		chk(32'(rsel[R_FX]), 32'(RATE_ALT2));
		chk(32'(rsel[R_PULSE]), 32'(RATE_SYS2));
		chk(32'(rsel[R_CORE2]), 32'h0);
		chk(32'(rsel[R_OUT]), 32'(RATE_SYS3));
		chk(32'(rsel[R_IN]), 32'(RATE_SYS1));
		chk(32'(rsel[R_PORT1]), 32'(RATE_SYS2));
		chk(32'(rsel[R_PORT2]), 32'(RATE_SYS1));
	endtask : t_rates

	task automatic t_map();
		apb(1'b1, MIX_LAST_IDX, 32'h0000_0040);
		apb(1'b0, MIX_LAST_IDX, 32'h0);
		chk(rd, 32'h0000_0040);
		apb(1'b0, MIX_LAST_IDX + 16'h1, 32'h0);
		chk({31'h0, serr}, 32'h1);
		chk(rd, 32'h0);
	endtask : t_map

	task automatic t_underclock();
		apb(1'b1, CLK_BUDGET_IDX, {16'h0, PATH_CYCLES});
		apb(1'b1, MIX_FIRST_IDX, 32'h01);
		apb(1'b1, MIX_FIRST_IDX + 16'h2, 32'h02);
		apb(1'b0, MIX_FIRST_IDX, 32'h0);
		chk(rd, 32'h0000_8001);
		apb(1'b0, MIX_FIRST_IDX + 16'h2, 32'h0);
		chk(rd, 32'h0000_8000);
		chk({31'h0, uerr}, 32'h1);
		apb(1'b1, ERR_STAT_IDX, 32'h1);
		@(negedge clk);
		chk({31'h0, uerr}, 32'h0);
		apb(1'b1, CLK_BUDGET_IDX, {16'h0, BUDGET_RST});
		apb(1'b1, MIX_FIRST_IDX + 16'h8, 32'h60);
		@(negedge clk);
		chk({24'h0, sel2[0]}, 32'h0);
		chk({24'h0, sel1[0]}, 32'h01);
	endtask : t_underclock

	task automatic t_pwm();
		int h1;
		int h2;
		apb(1'b1, PULSE_LVL1_IDX, 32'h40);
		apb(1'b1, PULSE_CTRL_IDX, 32'h11);
		count_pwm(600, 256, h1, h2);
		chk(32'(h1), 32'h40);
		chk(32'(h2), 32'h0);
		apb(1'b1, PULSE_CTRL_IDX, 32'h03);
		au1[0] <= 16'sh4000;
		count_pwm(600, 256, h1, h2);
		chk(32'(h1), 32'hC0);
		chk(32'(h2), 32'h80);
		apb(1'b1, PULSE_LVL2_IDX, 32'h20);
		apb(1'b1, PULSE_CTRL_IDX, 32'h0123);
		count_pwm(1100, 512, h1, h2);
		chk(32'(h1), 32'h180);
		chk(32'(h2), 32'h40);
		apb(1'b1, PULSE_CTRL_IDX, 32'h0);
		count_pwm(4, 256, h1, h2);
		chk(32'(h1 + h2), 32'h0);
	endtask : t_pwm

	initial
	begin
		arst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 16'h0;
		pwdata = 32'h0;
		au1 = '{4{16'sh0}};
		au2 = '{4{16'sh0}};
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		t_reset();
		t_rates();
		t_map();
		t_underclock();
		t_pwm();
		stop_test();
	end

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_mismatch++;
			stop_test();
		end
	end
endmodule : crpg_top_bench

bind crpg_top crpg_properties u_props (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
	.i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
	.i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
	.o_mix1_sel(o_mix1_sel), .o_rate_sel(o_rate_sel), .o_rate_alt(o_rate_alt),
	.o_underclock_err(o_underclock_err));
